/* File: src/egrmk_pkg.sv */
// shared constants and types for the egress tag priority remark block
`default_nettype none
package egrmk_pkg;

    // register bus geometry
    localparam int unsigned EGRMK_ADDR_W    = 12;
    localparam int unsigned EGRMK_DATA_W    = 32;

    // register byte offsets
    localparam logic [11:0] EGRMK_OFF_CTRL   = 12'h000;
    localparam logic [11:0] EGRMK_OFF_COUNT  = 12'h008;
    // region selects on address bits 11:8
    localparam logic [3:0]  EGRMK_RGN_PORT_EN   = 4'h1;
    localparam logic [3:0]  EGRMK_RGN_PORT_DFLT = 4'h2;
    localparam logic [3:0]  EGRMK_RGN_MAP8      = 4'h4;
    localparam logic [3:0]  EGRMK_RGN_DSCP_IN   = 4'h5;
    localparam logic [3:0]  EGRMK_RGN_DSCP_OUT  = 4'h6;

    // eight-entry tables, 0x20 apart inside the map8 region
    localparam int unsigned EGRMK_NUM_MAP8   = 6;
    localparam logic [2:0]  EGRMK_MAP8_LAST  = 3'h5;
    localparam logic [2:0]  EGRMK_TBL_OUTER  = 3'h3;
    localparam int unsigned EGRMK_DSCP_ENTRIES = 64;

    // port_remark_enables fields
    localparam int unsigned EGRMK_EN_INNER_BIT = 0;
    localparam int unsigned EGRMK_EN_OUTER_BIT = 1;
    localparam int unsigned EGRMK_EN_DSCP_BIT  = 2;
    localparam int unsigned EGRMK_EN_DEI_BIT   = 3;
    localparam int unsigned EGRMK_EN_W         = 4;

    // global_remark_control fields
    localparam int unsigned EGRMK_OUT_DFLT_SEL_BIT = 0;
    localparam int unsigned EGRMK_IN_DFLT_SEL_BIT  = 1;
    localparam int unsigned EGRMK_OUT_SRC_LSB      = 6;
    localparam int unsigned EGRMK_IN_SRC_LSB       = 8;
    localparam int unsigned EGRMK_CTRL_W           = 10;

    // port_default_priority fields
    localparam int unsigned EGRMK_OUT_DSRC_LSB  = 0;
    localparam int unsigned EGRMK_IN_DSRC_BIT   = 2;
    localparam int unsigned EGRMK_OUT_DVAL_LSB  = 4;
    localparam int unsigned EGRMK_IN_DVAL_LSB   = 8;
    localparam int unsigned EGRMK_DFLT_W        = 11;

    // reset values
    localparam logic [9:0]  EGRMK_CTRL_RST  = 10'h000;
    localparam logic [3:0]  EGRMK_EN_RST    = 4'h0;
    localparam logic [10:0] EGRMK_DFLT_RST  = 11'h000;
    localparam logic [2:0]  EGRMK_DSCP_RST  = 3'h0;

    // bus responses
    localparam logic [1:0]  EGRMK_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  EGRMK_RESP_SLVERR = 2'h2;

    // remark source selector
    typedef enum logic [1:0] {
        EGRMK_SRC_INTERNAL = 2'h0,
        EGRMK_SRC_RX_INNER = 2'h1,
        EGRMK_SRC_RX_OUTER = 2'h2,
        EGRMK_SRC_DSCP     = 2'h3
    } egrmk_src_t;

    // default outer priority method
    typedef enum logic [1:0] {
        EGRMK_DOUT_INTERNAL = 2'h0,
        EGRMK_DOUT_VALUE    = 2'h1,
        EGRMK_DOUT_RX_INNER = 2'h2,
        EGRMK_DOUT_RSVD     = 2'h3
    } egrmk_dout_t;

endpackage
`default_nettype wire

/* File: src/egrmk_top.sv */
// egress inner/outer tag priority remark with AXI4-Lite register access
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module egrmk_top
    import egrmk_pkg::*;
#(
    parameter int unsigned NUM_PORTS = 56,
    parameter int unsigned PORT_W    = 6
) (
    // clock and reset
    input  wire  logic                    MCLK,
    input  wire  logic                    RST_N,
    // axi4-lite write address and data
    input  wire  logic [EGRMK_ADDR_W-1:0] AWADDR,
    input  wire  logic [2:0]              AWPROT,
    input  wire  logic                    AWVALID,
    output logic                          AWREADY,
    input  wire  logic [31:0]             WDATA,
    input  wire  logic [3:0]              WSTRB,
    input  wire  logic                    WVALID,
    output logic                          WREADY,
    // axi4-lite write response
    output logic [1:0]                    BRESP,
    output logic                          BVALID,
    input  wire  logic                    BREADY,
    // axi4-lite read
    input  wire  logic [EGRMK_ADDR_W-1:0] ARADDR,
    input  wire  logic [2:0]              ARPROT,
    input  wire  logic                    ARVALID,
    output logic                          ARREADY,
    output logic [31:0]                   RDATA,
    output logic [1:0]                    RRESP,
    output logic                          RVALID,
    input  wire  logic                    RREADY,
    // packet descriptor from the forwarding pipeline
    input  wire  logic                    PKT_VALID,
    input  wire  logic [PORT_W-1:0]       PKT_RX_PORT,
    input  wire  logic [PORT_W-1:0]       PKT_TX_PORT,
    input  wire  logic [2:0]              PKT_INT_PRI,
    input  wire  logic                    PKT_RX_INNER_TAGGED,
    input  wire  logic [2:0]              PKT_RX_INNER_PRI,
    input  wire  logic                    PKT_RX_OUTER_TAGGED,
    input  wire  logic [2:0]              PKT_RX_OUTER_PRI,
    input  wire  logic                    PKT_IS_IP,
    input  wire  logic [5:0]              PKT_DSCP,
    // result to the egress packet editor
    output logic                          OUT_VALID,
    output logic [2:0]                    OUT_NEW_INNER_PRIORITY,
    output logic [2:0]                    OUT_NEW_OUTER_PRIORITY,
    output logic                          OUT_DIFFSERV_REMARK_ENABLE,
    output logic                          OUT_DROP_ELIGIBLE_REMARK_ENABLE
);

    logic [EGRMK_CTRL_W-1:0] ctrl;
    logic [EGRMK_EN_W-1:0]   port_en   [NUM_PORTS];
    logic [EGRMK_DFLT_W-1:0] port_dflt [NUM_PORTS];
    logic [2:0]              map8      [EGRMK_NUM_MAP8][8];
    logic [2:0]              dscp_in   [EGRMK_DSCP_ENTRIES];
    logic [2:0]              dscp_out  [EGRMK_DSCP_ENTRIES];
    logic [31:0]             pkt_count;

    // bus state
    logic                    aw_full;
    logic                    w_full;
    logic [EGRMK_ADDR_W-1:0] aw_addr;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    wr_fire;
    logic [32:0]             wr_old;
    logic [32:0]             rd_new;
    logic [31:0]             wr_val;

    // port index is in range for a per-port region
    function automatic logic port_ok(input logic [EGRMK_ADDR_W-1:0] a);
        port_ok = (int'(a[7:2]) < NUM_PORTS);
    endfunction

    // mapped flag in bit 32, register content below it
    function automatic logic [32:0] rd_word(input logic [EGRMK_ADDR_W-1:0] a);
        rd_word = 33'h0;
        if (a == EGRMK_OFF_CTRL) begin
            rd_word = {1'b1, 22'h0, ctrl};
        end else if (a == EGRMK_OFF_COUNT) begin
            rd_word = {1'b1, pkt_count};
        end else if (a[1:0] == 2'h0) begin
            unique case (a[11:8])
                EGRMK_RGN_PORT_EN:
                    if (port_ok(a)) rd_word = {1'b1, 28'h0, port_en[a[7:2]]};
                EGRMK_RGN_PORT_DFLT:
                    if (port_ok(a)) rd_word = {1'b1, 21'h0, port_dflt[a[7:2]]};
                EGRMK_RGN_MAP8:
                    if (a[7:5] <= EGRMK_MAP8_LAST)
                        rd_word = {1'b1, 29'h0, map8[a[7:5]][a[4:2]]};
                EGRMK_RGN_DSCP_IN:  rd_word = {1'b1, 29'h0, dscp_in[a[7:2]]};
                EGRMK_RGN_DSCP_OUT: rd_word = {1'b1, 29'h0, dscp_out[a[7:2]]};
                default:            rd_word = 33'h0;
            endcase
        end
    endfunction

    // table lookup for one remark source; bit 3 says the source exists
    function automatic logic [3:0] remark(input egrmk_src_t src, input logic outer);
        logic [2:0] b;
        b = outer ? EGRMK_TBL_OUTER : 3'h0;
        unique case (src)
            EGRMK_SRC_INTERNAL: remark = {1'b1, map8[b][PKT_INT_PRI]};
            EGRMK_SRC_RX_INNER:
                remark = {PKT_RX_INNER_TAGGED, map8[b + 3'h1][PKT_RX_INNER_PRI]};
            EGRMK_SRC_RX_OUTER:
                remark = {PKT_RX_OUTER_TAGGED, map8[b + 3'h2][PKT_RX_OUTER_PRI]};
            EGRMK_SRC_DSCP:
                remark = {PKT_IS_IP, outer ? dscp_out[PKT_DSCP] : dscp_in[PKT_DSCP]};
        endcase
    endfunction

    // ---------------- axi4-lite write channel ----------------
    // address and data are taken independently; the response waits for both
    assign wr_fire = aw_full && w_full && !BVALID;
    // a process, not an assign, so that table writes re-run the decode
    always_comb begin
        wr_old = rd_word(aw_addr);
        rd_new = rd_word(ARADDR);
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_val[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : wr_old[i*8 +: 8];
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
            AWREADY <= 1'b1;
        end else if (AWVALID && AWREADY) begin
            aw_full <= 1'b1;
            aw_addr <= AWADDR;
            AWREADY <= 1'b0;
        end else if (BVALID && BREADY) begin
            AWREADY <= 1'b1;
        end else if (wr_fire) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            WREADY <= 1'b1;
        end else if (WVALID && WREADY) begin
            w_full <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
            WREADY <= 1'b0;
        end else if (BVALID && BREADY) begin
            WREADY <= 1'b1;
        end else if (wr_fire) begin
            w_full <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            BVALID <= 1'b0;
            BRESP  <= EGRMK_RESP_OKAY;
        end else if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP  <= wr_old[32] ? EGRMK_RESP_OKAY : EGRMK_RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // ---------------- axi4-lite read channel ----------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= '0;
            RRESP   <= EGRMK_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= rd_new[31:0];
            RRESP   <= rd_new[32] ? EGRMK_RESP_OKAY : EGRMK_RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
        end
    end

    // ---------------- register storage ----------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl <= EGRMK_CTRL_RST;
        end else if (wr_fire && aw_addr == EGRMK_OFF_CTRL) begin
            ctrl <= wr_val[EGRMK_CTRL_W-1:0];
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                port_en[p]   <= EGRMK_EN_RST;
                port_dflt[p] <= EGRMK_DFLT_RST;
            end
        end else if (wr_fire && wr_old[32] && port_ok(aw_addr)) begin
            if (aw_addr[11:8] == EGRMK_RGN_PORT_EN) begin
                port_en[aw_addr[7:2]] <= wr_val[EGRMK_EN_W-1:0];
            end
            if (aw_addr[11:8] == EGRMK_RGN_PORT_DFLT) begin
                port_dflt[aw_addr[7:2]] <= wr_val[EGRMK_DFLT_W-1:0];
            end
        end
    end

    // eight-entry tables start as identity so an enabled remark is transparent
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int t = 0; t < EGRMK_NUM_MAP8; t++) begin
                for (int e = 0; e < 8; e++) begin
                    map8[t][e] <= 3'(e);
                end
            end
        end else if (wr_fire && wr_old[32] && aw_addr[11:8] == EGRMK_RGN_MAP8) begin
            map8[aw_addr[7:5]][aw_addr[4:2]] <= wr_val[2:0];
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int d = 0; d < EGRMK_DSCP_ENTRIES; d++) begin
                dscp_in[d]  <= EGRMK_DSCP_RST;
                dscp_out[d] <= EGRMK_DSCP_RST;
            end
        end else if (wr_fire && aw_addr[1:0] == 2'h0) begin
            if (aw_addr[11:8] == EGRMK_RGN_DSCP_IN) begin
                dscp_in[aw_addr[7:2]] <= wr_val[2:0];
            end
            if (aw_addr[11:8] == EGRMK_RGN_DSCP_OUT) begin
                dscp_out[aw_addr[7:2]] <= wr_val[2:0];
            end
        end
    end

    // ---------------- priority decision ----------------
    logic [EGRMK_EN_W-1:0]   tx_en;
    logic [EGRMK_DFLT_W-1:0] in_cfg;
    logic [EGRMK_DFLT_W-1:0] out_cfg;
    logic [2:0]              out_dval;
    logic [2:0]              dflt_inner;
    logic [2:0]              dflt_outer;
    logic [3:0]              rm_inner;
    logic [3:0]              rm_outer;
    logic [2:0]              next_inner;
    logic [2:0]              next_outer;

    always_comb begin
        tx_en   = port_en[PKT_TX_PORT];
        // settings of rx or tx port, chosen globally per tag
        in_cfg  = ctrl[EGRMK_IN_DFLT_SEL_BIT] ? port_dflt[PKT_TX_PORT]
                                              : port_dflt[PKT_RX_PORT];
        out_cfg = ctrl[EGRMK_OUT_DFLT_SEL_BIT] ? port_dflt[PKT_TX_PORT]
                                               : port_dflt[PKT_RX_PORT];
        // internal priority is taken as delivered by the selection stage
        dflt_inner = in_cfg[EGRMK_IN_DSRC_BIT] ? in_cfg[EGRMK_IN_DVAL_LSB +: 3]
                                               : PKT_INT_PRI;
        out_dval = out_cfg[EGRMK_OUT_DVAL_LSB +: 3];
        unique case (egrmk_dout_t'(out_cfg[EGRMK_OUT_DSRC_LSB +: 2]))
            EGRMK_DOUT_INTERNAL: dflt_outer = PKT_INT_PRI;
            EGRMK_DOUT_VALUE:    dflt_outer = out_dval;
            EGRMK_DOUT_RX_INNER:
                dflt_outer = PKT_RX_INNER_TAGGED ? PKT_RX_INNER_PRI : out_dval;
            // reserved code behaves as the port value so the tag is never undefined
            EGRMK_DOUT_RSVD:     dflt_outer = out_dval;
        endcase
        rm_inner = remark(egrmk_src_t'(ctrl[EGRMK_IN_SRC_LSB +: 2]), 1'b0);
        rm_outer = remark(egrmk_src_t'(ctrl[EGRMK_OUT_SRC_LSB +: 2]), 1'b1);
        if (!PKT_RX_INNER_TAGGED) begin
            next_inner = dflt_inner;
        end else if (!tx_en[EGRMK_EN_INNER_BIT]) begin
            next_inner = PKT_RX_INNER_PRI;
        end else begin
            next_inner = rm_inner[3] ? rm_inner[2:0] : dflt_inner;
        end
        if (!PKT_RX_OUTER_TAGGED) begin
            next_outer = dflt_outer;
        end else if (!tx_en[EGRMK_EN_OUTER_BIT]) begin
            next_outer = PKT_RX_OUTER_PRI;
        end else begin
            next_outer = rm_outer[3] ? rm_outer[2:0] : dflt_outer;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            OUT_VALID                       <= 1'b0;
            OUT_NEW_INNER_PRIORITY          <= 3'h0;
            OUT_NEW_OUTER_PRIORITY          <= 3'h0;
            OUT_DIFFSERV_REMARK_ENABLE      <= 1'b0;
            OUT_DROP_ELIGIBLE_REMARK_ENABLE <= 1'b0;
        end else begin
            OUT_VALID <= PKT_VALID;
            if (PKT_VALID) begin
                OUT_NEW_INNER_PRIORITY          <= next_inner;
                OUT_NEW_OUTER_PRIORITY          <= next_outer;
                OUT_DIFFSERV_REMARK_ENABLE      <= tx_en[EGRMK_EN_DSCP_BIT];
                OUT_DROP_ELIGIBLE_REMARK_ENABLE <= tx_en[EGRMK_EN_DEI_BIT];
            end
        end
    end

    // wraps silently; software reads differences
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pkt_count <= 32'h0;
        end else if (PKT_VALID) begin
            pkt_count <= pkt_count + 32'h1;
        end
    end

endmodule

`default_nettype wire

/* File: dv/egrmk_sva.sv */
// concurrent checks on the remark block ports
`timescale 1ns/1ps
`default_nettype none
module egrmk_sva (
    // clock and reset
    input wire logic        MCLK,
    input wire logic        RST_N,
    // register bus
    input wire logic        AWVALID,
    input wire logic        AWREADY,
    input wire logic        WVALID,
    input wire logic        WREADY,
    input wire logic        BVALID,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic [31:0] RDATA,
    input wire logic        RVALID,
    input wire logic        RREADY,
    // packet path
    input wire logic        PKT_VALID,
    input wire logic        OUT_VALID,
    input wire logic [2:0]  OUT_NEW_INNER_PRIORITY,
    input wire logic [2:0]  OUT_NEW_OUTER_PRIORITY,
    input wire logic        OUT_DIFFSERV_REMARK_ENABLE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    a_out_one_later: assert property (PKT_VALID |=> OUT_VALID)
        else $error("result pulse missing");
    a_out_has_cause: assert property (OUT_VALID |-> $past(PKT_VALID))
        else $error("result pulse without descriptor");
    a_inner_holds: assert property (!OUT_VALID |-> $stable(OUT_NEW_INNER_PRIORITY))
        else $error("inner result moved between pulses");
    a_outer_holds: assert property (!OUT_VALID |-> $stable(OUT_NEW_OUTER_PRIORITY))
        else $error("outer result moved between pulses");
    a_dscp_en_holds: assert property (!OUT_VALID |-> $stable(OUT_DIFFSERV_REMARK_ENABLE))
        else $error("diffserv enable moved between pulses");
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
        else $error("write response late");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read data late");
    a_read_stands: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped before taken");
    a_no_ready_in_b: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write accepted while response pending");

    // a single cycle stall hides nothing from the bench, it only proves reach
    cover property (PKT_VALID && $past(PKT_VALID));
    cover property (RVALID && !RREADY);
    cover property (BVALID && !AWREADY);
endmodule

bind egrmk_top egrmk_sva u_sva (
    .MCLK(MCLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
    .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .PKT_VALID(PKT_VALID),
    .OUT_VALID(OUT_VALID), .OUT_NEW_INNER_PRIORITY(OUT_NEW_INNER_PRIORITY),
    .OUT_NEW_OUTER_PRIORITY(OUT_NEW_OUTER_PRIORITY),
    .OUT_DIFFSERV_REMARK_ENABLE(OUT_DIFFSERV_REMARK_ENABLE)
);
`default_nettype wire

/* File: dv/egrmk_editor_model.sv */
// egress editor model that takes each remark result
`timescale 1ns/1ps
`default_nettype none
module egrmk_editor_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       res_valid,
    input  wire logic [7:0] res,
    output logic            got,
    output logic [7:0]      held
);
    // no backpressure: a result not taken in its cycle is lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            got  <= 1'b0;
            held <= 8'h00;
        end else begin
            got <= res_valid;
            if (res_valid) begin
                held <= res;
            end
        end
    end
endmodule
`default_nettype wire

/* File: dv/egress_tag_priority_remark_tb.sv */
// self-checking bench for the egress priority remark block
`timescale 1ns/1ps
`default_nettype none
module egress_tag_priority_remark_tb;
    import egrmk_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, lf = 32'hea4e3a30;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, pv = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, ov, got;
    logic [1:0]  bresp, rresp;
    logic [5:0]  prx = 6'h0, ptx = 6'h0, pdscp = 6'h0;
    logic [2:0]  pip = 3'h0, pri = 3'h0, pro = 3'h0, oi, oo;
    logic        pit = 1'b0, pot = 1'b0, pisip = 1'b0, odscp, odei;
    logic [7:0]  held, exq[$];
    logic [9:0]  ctl = 10'h0;
    logic [3:0]  sen[4] = '{default: 4'h0};
    logic [10:0] sdf[4] = '{default: 11'h0};
    logic [2:0]  smap[6][8], sdi[64] = '{default: 3'h0}, sdo[64] = '{default: 3'h0};
    int          num_errors = 0, comparisons = 0;

    always #5 mclk = ~mclk;

    egrmk_top uut (
        .MCLK(mclk), .RST_N(rst_n), .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(rready), .PKT_VALID(pv), .PKT_RX_PORT(prx),
        .PKT_TX_PORT(ptx), .PKT_INT_PRI(pip), .PKT_RX_INNER_TAGGED(pit),
        .PKT_RX_INNER_PRI(pri), .PKT_RX_OUTER_TAGGED(pot), .PKT_RX_OUTER_PRI(pro),
        .PKT_IS_IP(pisip), .PKT_DSCP(pdscp), .OUT_VALID(ov), .OUT_NEW_INNER_PRIORITY(oi),
        .OUT_NEW_OUTER_PRIORITY(oo), .OUT_DIFFSERV_REMARK_ENABLE(odscp),
        .OUT_DROP_ELIGIBLE_REMARK_ENABLE(odei)
    );

    egrmk_editor_model u_editor (
        .clk(mclk), .rst_n(rst_n), .res_valid(ov), .res({odei, odscp, oi, oo}),
        .got(got), .held(held)
    );

    function logic [31:0] rnd();
        lf = lf[0] ? (lf >> 1) ^ 32'h80200003 : lf >> 1;
        return lf;
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task stop_hung();
        num_errors++;
        report_and_stop();
    endtask

    // r packs one descriptor: ports 1:0 and 3:2, then pri, tags, dscp fields
    function automatic logic [7:0] expect_res(input logic [31:0] r);
        logic [2:0]  ip, ri, ro, din, dout, ni, no;
        logic [10:0] c;
        logic [3:0]  en;
        ip = r[6:4];
        ri = r[10:8];
        ro = r[14:12];
        en = sen[r[3:2]];
        c = sdf[ctl[1] ? r[3:2] : r[1:0]];
        din = c[2] ? c[10:8] : ip;
        c = sdf[ctl[0] ? r[3:2] : r[1:0]];
        dout = c[1:0] == 2'h0 ? ip : (c[1:0] == 2'h2 && r[7]) ? ri : c[6:4];
        case (ctl[9:8])
            2'h0: ni = smap[0][ip];
            2'h1: ni = smap[1][ri];
            2'h2: ni = r[11] ? smap[2][ro] : din;
            default: ni = r[15] ? sdi[r[21:16]] : din;
        endcase
        case (ctl[7:6])
            2'h0: no = smap[3][ip];
            2'h1: no = r[7] ? smap[4][ri] : dout;
            2'h2: no = smap[5][ro];
            default: no = r[15] ? sdo[r[21:16]] : dout;
        endcase
        ni = !r[7] ? din : en[0] ? ni : ri;
        no = !r[11] ? dout : en[1] ? no : ro;
        return {en[3:2], ni, no};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
        if (n >= 50) stop_hung();
    endtask

    // rready comes late on purpose so the slave has to hold its answer
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            else if (!arvalid && !rready) rready <= 1'b1;
        end while (!(rvalid && rready) && n < 50);
        rready <= 1'b0;
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
        if (n >= 50) stop_hung();
    endtask

    task automatic cfg();
        logic [31:0] r, d, m;
        logic [11:0] a;
        logic [2:0]  t;
        r = rnd();
        d = rnd();
        t = r[5:3] % 3'h6;
        case (r[2:0])
            3'h1: a = {4'h1, 4'h0, r[4:3], 2'h0};
            3'h2: a = {4'h2, 4'h0, r[4:3], 2'h0};
            3'h3, 3'h4: a = {4'h4, t, r[8:6], 2'h0};
            3'h5: a = {4'h5, r[11:6], 2'h0};
            3'h6: a = {4'h6, r[11:6], 2'h0};
            default: a = EGRMK_OFF_CTRL;
        endcase
        m = a[11:8] == 4'h0 ? 32'h3ff : a[11:8] == 4'h1 ? 32'hf
            : a[11:8] == 4'h2 ? 32'h7ff : 32'h7;
        wr(a, d, EGRMK_RESP_OKAY);
        d = d & m;
        case (a[11:8])
            4'h0: ctl = d[9:0];
            4'h1: sen[a[3:2]] = d[3:0];
            4'h2: sdf[a[3:2]] = d[10:0];
            4'h4: smap[a[7:5]][a[4:2]] = d[2:0];
            4'h5: sdi[a[7:2]] = d[2:0];
            default: sdo[a[7:2]] = d[2:0];
        endcase
        rd(a, d, EGRMK_RESP_OKAY);
    endtask

    task automatic burst(input int len);
        logic [31:0] r;
        for (int i = 0; i < len; i++) begin
            @(posedge mclk);
            r = rnd();
            pv <= 1'b1;
            {pdscp, pisip, pro, pot, pri, pit, pip, ptx, prx} <= {r[21:16], r[15], r[14:12],
                r[11], r[10:8], r[7], r[6:4], 4'h0, r[3:2], 4'h0, r[1:0]};
            exq.push_back(expect_res(r));
        end
        @(posedge mclk);
        pv <= 1'b0;
    endtask

    always @(posedge mclk) begin
        if (got === 1'b1) begin
            if (exq.size() == 0) check(32'h1, 32'h0);
            else check({24'h0, held}, {24'h0, exq.pop_front()});
        end
    end

    initial begin
        for (int t = 0; t < 6; t++)
            for (int e = 0; e < 8; e++)
                smap[t][e] = e[2:0];
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (int t = 0; t < 6; t++)
            for (int e = 0; e < 8; e++)
                rd({4'h4, t[2:0], e[2:0], 2'h0}, 32'(smap[t][e]), EGRMK_RESP_OKAY);
        rd(EGRMK_OFF_CTRL, 32'h0, EGRMK_RESP_OKAY);
        rd(12'h100, 32'h0, EGRMK_RESP_OKAY);
        rd(12'h1e0, 32'h0, EGRMK_RESP_SLVERR);
        wr(12'h700, 32'hffffffff, EGRMK_RESP_SLVERR);
        wr(EGRMK_OFF_COUNT, 32'h5, EGRMK_RESP_OKAY);
        rd(12'h700, 32'h0, EGRMK_RESP_SLVERR);
        burst(4);
        // four descriptors so far; the earlier write to the counter must not stick
        rd(EGRMK_OFF_COUNT, 32'h4, EGRMK_RESP_OKAY);
        $display("reset state test done");
        repeat (60) begin
            repeat (3) cfg();
            burst(1 + rnd() % 4);
        end
        for (int n = 0; n < 20 && exq.size() > 0; n++) @(posedge mclk);
        check(32'(exq.size()), 32'h0);
        $display("random remark test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
